// ---- error_classifier.sv ----
`default_nettype none
module error_classifier #(
	parameter longint estab_limit = err_class_pkg::estab_cycles
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] unit_kind,
	input wire logic length_fault,
	input wire logic mac_fault,
	input wire logic flag_check,
	input wire logic flag_value,
	input wire logic flag_expected,
	input wire logic field_fault,
	input wire logic au1_struct_fault,
	input wire logic identity_check,
	input wire logic identity_match,
	input wire logic centre_unspecified,
	input wire logic candidate_match,
	input wire logic sequence_fault,
	input wire logic replay_fault,
	input wire logic connect_given,
	input wire logic key_missing,
	input wire logic key_invalid,
	input wire logic key_other_fault,
	input wire logic feature_unsupported,
	input wire logic setup_start,
	input wire logic ar_received,
	input wire logic local_valid,
	input wire logic [7:0] local_reason,
	input wire logic [7:0] local_sub_reason,
	input wire logic [3:0] local_action,
	output logic code_valid,
	output logic [7:0] reason,
	output logic [7:0] sub_reason,
	output logic [3:0] action,
	output logic user_release_indication,
	output logic user_error_report,
	output logic transport_release_request,
	output logic send_di_unit,
	output logic unit_rejected
);
	localparam logic [3:0] a_rel = 4'(1 << err_class_pkg::act_release);
	localparam logic [3:0] a_rep = 4'(1 << err_class_pkg::act_report);
	localparam logic [3:0] a_tr = 4'(1 << err_class_pkg::act_transport);
	localparam logic [3:0] a_rej = 4'(1 << err_class_pkg::act_reject);

	typedef enum logic [1:0] {idle, waiting_ar} setup_state_t;
	setup_state_t state_reg, state_next;

	err_code_if pick();
	logic timeout_hit;

	setup_timer #(.limit_cycles(estab_limit)) timer_i (
		.clock(clock),
		.reset_n(reset_n),
		.start(setup_start),
		.stop(ar_received),
		.expired(timeout_hit)
	);

	wire logic is_au1 = unit_kind == 3'(err_class_pkg::unit_au1);
	wire logic is_au2 = unit_kind == 3'(err_class_pkg::unit_au2);
	wire logic is_au3 = unit_kind == 3'(err_class_pkg::unit_au3);
	wire logic is_ar = unit_kind == 3'(err_class_pkg::unit_ar);
	wire logic is_dt = unit_kind == 3'(err_class_pkg::unit_dt);
	wire logic is_di = unit_kind == 3'(err_class_pkg::unit_di);
	wire logic is_auth = is_au1 || is_au2 || is_au3 || is_ar;

	// flag only judged on units that passed the mac and carry one
	wire logic flag_fault = flag_check && !mac_fault && !length_fault &&
		!is_au1 && !is_di && (flag_value != flag_expected);
	wire logic ident_ok = centre_unspecified ? candidate_match : identity_match;
	wire logic ident_fault = identity_check && is_au2 && !ident_ok;
	wire logic any_field = field_fault || (is_au1 && au1_struct_fault) || ident_fault;
	wire logic replay_hit = replay_fault && is_auth && !sequence_fault;
	wire logic key_hit = key_missing || key_invalid || key_other_fault;

	function automatic logic [7:0] clean_reason(input logic [7:0] r);
		if (r >= err_class_pkg::reserved_low && r <= err_class_pkg::reserved_high) begin
			clean_reason = err_class_pkg::code_unknown;
		end else begin
			clean_reason = r;
		end
	endfunction : clean_reason

	// fixed check order, first hit wins
	always_comb begin
		pick.hit = 1'b1;
		pick.reason = err_class_pkg::code_unknown;
		pick.sub_reason = err_class_pkg::code_unknown;
		pick.action = a_rel;
		if (length_fault) begin
			pick.reason = err_class_pkg::reason_length;
			if (is_au1) begin
				pick.sub_reason = err_class_pkg::sub_1;
				pick.action = a_rej;
			end else if (is_au2) begin
				pick.sub_reason = err_class_pkg::sub_2;
			end else if (is_au3) begin
				pick.sub_reason = err_class_pkg::sub_3;
				pick.action = a_tr;
			end else if (is_dt) begin
				pick.sub_reason = err_class_pkg::sub_5;
			end else if (is_ar) begin
				pick.sub_reason = err_class_pkg::sub_8;
			end
		end else if (mac_fault) begin
			pick.reason = err_class_pkg::reason_mac;
			if (is_au2) begin
				pick.sub_reason = err_class_pkg::sub_2;
			end else if (is_au3) begin
				pick.sub_reason = err_class_pkg::sub_3;
				pick.action = a_tr;
			end else if (is_ar) begin
				pick.sub_reason = err_class_pkg::sub_4;
			end else begin
				pick.sub_reason = err_class_pkg::sub_1;
				pick.action = a_rep;
			end
		end else if (flag_fault) begin
			pick.reason = err_class_pkg::reason_flag;
			pick.sub_reason = flag_value ? err_class_pkg::sub_2 : err_class_pkg::sub_1;
			if (flag_value && !connect_given) begin
				pick.sub_reason = err_class_pkg::code_unknown;
			end
		end else if (any_field) begin
			pick.reason = err_class_pkg::reason_field;
			pick.action = a_rej;
			if (ident_fault) begin
				pick.sub_reason = err_class_pkg::sub_4;
				pick.action = a_rel;
			end else if (is_au1 && au1_struct_fault) begin
				pick.sub_reason = err_class_pkg::sub_5;
			end else begin
				pick.sub_reason = err_class_pkg::sub_1;
			end
		end else if (sequence_fault) begin
			pick.reason = err_class_pkg::reason_sequence;
			if (is_au1) begin
				pick.sub_reason = err_class_pkg::sub_1;
			end else if (is_au2) begin
				pick.sub_reason = err_class_pkg::sub_2;
				pick.action = a_tr;
			end else if (is_au3) begin
				pick.sub_reason = err_class_pkg::sub_3;
			end
		end else if (replay_hit) begin
			pick.reason = err_class_pkg::reason_replay;
			pick.sub_reason = err_class_pkg::sub_1;
		end else if (key_hit) begin
			pick.reason = err_class_pkg::reason_key;
			if (key_missing) begin
				pick.sub_reason = err_class_pkg::sub_2;
			end else if (key_invalid) begin
				pick.sub_reason = err_class_pkg::sub_4;
			end else begin
				pick.sub_reason = err_class_pkg::sub_3;
			end
		end else if (feature_unsupported) begin
			pick.reason = err_class_pkg::reason_key;
			pick.sub_reason = err_class_pkg::sub_29;
		end else if (timeout_hit && state_reg == waiting_ar) begin
			pick.reason = err_class_pkg::reason_timeout;
			pick.sub_reason = err_class_pkg::sub_3;
		end else if (local_valid) begin
			pick.reason = clean_reason(local_reason);
			pick.sub_reason = local_sub_reason;
			pick.action = (local_action == a_rel || local_action == a_rep ||
				local_action == a_tr || local_action == a_rej) ? local_action : a_rep;
		end else begin
			pick.hit = 1'b0;
			pick.action = err_class_pkg::action_none;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			idle: begin
				if (setup_start) begin
					state_next = waiting_ar;
				end
			end
			waiting_ar: begin
				if (ar_received || timeout_hit) begin
					state_next = idle;
				end
			end
			default: begin
				state_next = idle;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_reg <= idle;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			code_valid <= 1'b0;
			reason <= 8'h00;
			sub_reason <= 8'h00;
			action <= err_class_pkg::action_none;
		end else begin
			code_valid <= pick.hit;
			reason <= pick.hit ? pick.reason : 8'h00;
			sub_reason <= pick.hit ? pick.sub_reason : 8'h00;
			action <= pick.hit ? pick.action : err_class_pkg::action_none;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			user_release_indication <= 1'b0;
			user_error_report <= 1'b0;
			transport_release_request <= 1'b0;
			send_di_unit <= 1'b0;
			unit_rejected <= 1'b0;
		end else begin
			user_release_indication <= pick.hit && pick.action[err_class_pkg::act_release];
			user_error_report <= pick.hit && pick.action[err_class_pkg::act_report];
			transport_release_request <= pick.hit && pick.action[err_class_pkg::act_transport];
			send_di_unit <= pick.hit && pick.action[err_class_pkg::act_transport];
			unit_rejected <= pick.hit && pick.action[err_class_pkg::act_reject];
		end
	end
endmodule : error_classifier
`default_nettype wire

// ---- err_class_pkg.sv ----
// How it works
// - missing key gives release with 3/2; key not yet valid gives 3/4
// - other key management fault gives release with 3/3
// - unsupported requested safety feature gives release with 3/29
// - mac fault reason 4: sub 1 report, 2 and 4 release, 3 transport release
// - replayed authentication unit after establishment gives release with 5/1
// - direction flag checked only after good mac, never for au1 or di units
// - good mac with wrong direction flag gives release
// - direction flag fault reason 6: 0-for-1 is sub 1, 1-for-0 is sub 2 if connect given, else 127
// - set-up timeout before ar gives release with 7/3
// - invalid field 8/1 and malformed au1 8/5 are rejected silently
// - responder identity not acceptable in au2 gives release with 8/4
// - call to unspecified centre accepts any candidate centre identity
// - sequence faults reason 9: subs 1 and 3 release, sub 2 transport release
// - length fault reason 10: au1 reject, au3 transport, au2/dt/ar release
// - code 127 when no fitting code exists or the chosen code is undefined
// - reason codes 12 to 126 are never emitted; 128 up are implementation use
// - sub-reasons under implementation reasons are passed as implementation defined
// - release faults use release indication, internal faults the optional report
// - a transport release request always goes with a di unit
// - set-up supervision timeout is 40 s
`default_nettype none
package err_class_pkg;
	typedef enum logic [2:0] {
		unit_au1, unit_au2, unit_au3, unit_ar, unit_dt, unit_di, unit_other
	} unit_kind_t;
	localparam logic [7:0] reason_key = 8'h03;
	localparam logic [7:0] reason_mac = 8'h04;
	localparam logic [7:0] reason_replay = 8'h05;
	localparam logic [7:0] reason_flag = 8'h06;
	localparam logic [7:0] reason_timeout = 8'h07;
	localparam logic [7:0] reason_field = 8'h08;
	localparam logic [7:0] reason_sequence = 8'h09;
	localparam logic [7:0] reason_length = 8'h0a;
	localparam logic [7:0] code_unknown = 8'h7f;
	localparam logic [7:0] reserved_low = 8'h0c;
	localparam logic [7:0] reserved_high = 8'h7e;
	localparam logic [7:0] sub_1 = 8'h01;
	localparam logic [7:0] sub_2 = 8'h02;
	localparam logic [7:0] sub_3 = 8'h03;
	localparam logic [7:0] sub_4 = 8'h04;
	localparam logic [7:0] sub_5 = 8'h05;
	localparam logic [7:0] sub_8 = 8'h08;
	localparam logic [7:0] sub_29 = 8'h1d;
	// one-hot action bit positions
	localparam int act_release = 0;
	localparam int act_report = 1;
	localparam int act_transport = 2;
	localparam int act_reject = 3;
	localparam logic [3:0] action_none = 4'h0;
	localparam int clock_hz = 20000000;
	localparam int estab_timeout_s = 40;
	localparam longint estab_cycles = longint'(estab_timeout_s) * longint'(clock_hz);
	localparam int timer_width = 30;
endpackage : err_class_pkg
`default_nettype wire

// ---- err_code_if.sv ----
`default_nettype none
interface err_code_if;
	logic hit;
	logic [7:0] reason;
	logic [7:0] sub_reason;
	logic [3:0] action;
	modport source (output hit, output reason, output sub_reason, output action);
	modport sink (input hit, input reason, input sub_reason, input action);
endinterface : err_code_if
`default_nettype wire

// ---- setup_timer.sv ----
`default_nettype none
module setup_timer #(
	parameter longint limit_cycles = err_class_pkg::estab_cycles
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	input wire logic stop,
	output logic expired
);
	localparam int tw = err_class_pkg::timer_width;
	logic [tw-1:0] count_reg;
	logic running_reg;
	wire logic at_limit = running_reg && (count_reg == tw'(limit_cycles - 1));
	// a fresh start beats expiry so the new set-up stays supervised
	always_ff @(posedge clock) begin
		if (!reset_n || stop) begin
			running_reg <= 1'b0;
			count_reg <= '0;
		end else if (start) begin
			running_reg <= 1'b1;
			count_reg <= '0;
		end else if (at_limit) begin
			running_reg <= 1'b0;
			count_reg <= '0;
		end else if (running_reg) begin
			count_reg <= count_reg + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			expired <= 1'b0;
		end else begin
			expired <= at_limit && !stop && !start;
		end
	end
endmodule : setup_timer
`default_nettype wire

// ---- app_user_model.sv ----
`default_nettype none
module app_user_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic code_valid,
	output logic [7:0] seen_count
);
	timeunit 1ns;
	timeprecision 1ns;
	// user side: tallies every code handed over
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			seen_count <= 8'h00;
		end else if (code_valid) begin
			seen_count <= seen_count + 8'h01;
		end
	end
endmodule : app_user_model
`default_nettype wire

// ---- error_classifier_assertions.sv ----
`default_nettype none
module error_classifier_assertions (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] unit_kind,
	input wire logic length_fault,
	input wire logic mac_fault,
	input wire logic flag_check,
	input wire logic flag_value,
	input wire logic flag_expected,
	input wire logic code_valid,
	input wire logic [7:0] reason,
	input wire logic [7:0] sub_reason,
	input wire logic [3:0] action,
	input wire logic user_release_indication,
	input wire logic user_error_report,
	input wire logic transport_release_request,
	input wire logic send_di_unit,
	input wire logic unit_rejected
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	mac_au3_a: assert property (
		mac_fault && !length_fault && unit_kind == 3'h2 |=>
		code_valid && reason == 8'h04 && sub_reason == 8'h03 && action == 4'h4)
		else $error("mac fault on au3 misclassified");
	len_au1_a: assert property (
		length_fault && unit_kind == 3'h0 |=>
		reason == 8'h0a && sub_reason == 8'h01 && unit_rejected && !user_release_indication)
		else $error("au1 length fault not rejected");
	flag_low_a: assert property (
		flag_check && !mac_fault && !length_fault && !flag_value && flag_expected &&
		unit_kind inside {[3'h1:3'h4]} |=> reason == 8'h06 && sub_reason == 8'h01)
		else $error("flag fault code wrong");
	di_pair_a: assert property (
		send_di_unit == transport_release_request)
		else $error("transport release without di unit");
	idle_zero_a: assert property (
		!code_valid |-> reason == 8'h00 && sub_reason == 8'h00 && action == 4'h0)
		else $error("codes present without strobe");
	onehot_act_a: assert property (
		code_valid |-> $onehot(action))
		else $error("action not one-hot");
	strobe_map_a: assert property (
		{unit_rejected, transport_release_request, user_error_report,
		user_release_indication} == action)
		else $error("action strobes disagree with code");
	no_reserved_a: assert property (
		code_valid |-> !(reason inside {[8'h0c:8'h7e]}))
		else $error("reserved reason emitted");
endmodule : error_classifier_assertions
bind error_classifier error_classifier_assertions i_chk (.clock, .reset_n, .unit_kind,
	.length_fault, .mac_fault, .flag_check, .flag_value, .flag_expected, .code_valid,
	.reason, .sub_reason, .action, .user_release_indication, .user_error_report,
	.transport_release_request, .send_di_unit, .unit_rejected);
`default_nettype wire

// ---- safe_link_error_classifier_tb_top.sv ----
`default_nettype none
`define check_eq(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module safe_link_error_classifier_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [2:0] k; logic [17:0] e; logic [7:0] r; logic [7:0] s;
		logic [3:0] a;} row_t;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [17:0] ev = 18'h00000;
	logic start = 1'b0, ar = 1'b0, lv = 1'b0;
	logic [7:0] lr = 8'h00, ls = 8'h00, seen;
	logic [3:0] la = 4'h0, action;
	logic code_valid, rel, rep, tr, di, rej;
	logic [7:0] reason, sub_reason;
	wire logic [25:0] got = {code_valid, reason, sub_reason, action, rel, rep, tr, di, rej};
	int failures = 0, n_tests = 0, cycles = 0;
	int mark;
	row_t rows [28] = '{'{0, 'h4000, 3, 2, 1}, '{0, 'h8000, 3, 4, 1},
		'{0, 'h10000, 3, 3, 1}, '{0, 'h20000, 3, 29, 1},
		'{6, 'h2, 4, 1, 2}, '{1, 'h2, 4, 2, 1}, '{2, 'h2, 4, 3, 4}, '{3, 'h2, 4, 4, 1},
		'{0, 'h1000, 5, 1, 1}, '{0, 'h1800, 9, 1, 1},
		'{4, 'h14, 6, 1, 1}, '{4, 'h200c, 6, 2, 1},
		'{0, 'h14, 0, 0, 0}, '{5, 'h14, 0, 0, 0}, '{1, 'h16, 4, 2, 1},
		'{0, 'h20, 8, 1, 8}, '{0, 'h40, 8, 5, 8},
		'{1, 'h80, 8, 4, 1}, '{1, 'h680, 0, 0, 0}, '{1, 'h180, 0, 0, 0},
		'{0, 'h800, 9, 1, 1}, '{1, 'h800, 9, 2, 4}, '{2, 'h800, 9, 3, 1},
		'{0, 'h1, 10, 1, 8}, '{1, 'h1, 10, 2, 1}, '{2, 'h1, 10, 3, 4},
		'{4, 'h1, 10, 5, 1}, '{3, 'h1, 10, 8, 1}};
	error_classifier #(.estab_limit(20)) i_dut (.clock(clock), .reset_n(reset_n),
		.unit_kind(kind), .length_fault(ev[0]), .mac_fault(ev[1]), .flag_check(ev[2]),
		.flag_value(ev[3]), .flag_expected(ev[4]), .field_fault(ev[5]),
		.au1_struct_fault(ev[6]), .identity_check(ev[7]), .identity_match(ev[8]),
		.centre_unspecified(ev[9]), .candidate_match(ev[10]), .sequence_fault(ev[11]),
		.replay_fault(ev[12]), .connect_given(ev[13]), .key_missing(ev[14]),
		.key_invalid(ev[15]), .key_other_fault(ev[16]), .feature_unsupported(ev[17]),
		.setup_start(start), .ar_received(ar), .local_valid(lv), .local_reason(lr),
		.local_sub_reason(ls), .local_action(la), .code_valid(code_valid),
		.reason(reason), .sub_reason(sub_reason), .action(action),
		.user_release_indication(rel), .user_error_report(rep),
		.transport_release_request(tr), .send_di_unit(di), .unit_rejected(rej));
	app_user_model i_user (.clock(clock), .reset_n(reset_n), .code_valid(code_valid),
		.seen_count(seen));
	always #25 clock = ~clock;
	function automatic logic [25:0] expv(input logic [7:0] r, s, input logic [3:0] a);
		return {|a, r, s, a, a[0], a[1], a[2], a[2], a[3]};
	endfunction : expv
	task automatic print_verdict;
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	task automatic apply(input logic [2:0] k, input logic [17:0] e);
		@(posedge clock);
		kind <= k;
		ev <= e;
		@(posedge clock);
		ev <= 18'h00000;
		@(negedge clock);
	endtask : apply
	task automatic local_chk(input logic [7:0] r, s, input logic [3:0] a, input logic [7:0] er);
		@(posedge clock);
		{lv, lr, ls, la} <= {1'b1, r, s, a};
		@(posedge clock);
		lv <= 1'b0;
		@(negedge clock);
		`check_eq("local", expv(er, s, a), got)
	endtask : local_chk
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		`check_eq("reset", 26'h0000000, got)
		foreach (rows[i]) begin
			apply(rows[i].k, rows[i].e);
			`check_eq("row", expv(rows[i].r, rows[i].s, rows[i].a), got)
		end
		apply(3'h2, 18'h00023);
		`check_eq("priority", expv(8'h0a, 8'h03, 4'h4), got)
		@(posedge clock);
		ev <= 18'h04000;
		@(posedge clock);
		ev <= 18'h00002;
		@(negedge clock);
		`check_eq("back1", expv(8'h03, 8'h02, 4'h1), got)
		@(posedge clock);
		ev <= 18'h00000;
		@(negedge clock);
		`check_eq("back2", expv(8'h04, 8'h03, 4'h4), got)
		local_chk(8'h80, 8'h7e, 4'h2, 8'h80);
		local_chk(8'h20, 8'h01, 4'h1, 8'h7f);
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (20) @(posedge clock);
		@(negedge clock);
		`check_eq("early", 1'b0, code_valid)
		@(negedge clock);
		`check_eq("timeout", expv(8'h07, 8'h03, 4'h1), got)
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		// user tally has taken the timeout code by now
		mark = int'(seen);
		repeat (5) @(posedge clock);
		ar <= 1'b1;
		@(posedge clock);
		ar <= 1'b0;
		repeat (40) @(posedge clock);
		`check_eq("stopped", mark[7:0], seen)
		print_verdict();
	end
endmodule : safe_link_error_classifier_tb_top
`default_nettype wire
